// ### logic/osc_ctrl_pkg.sv
/*
 * osc_ctrl_pkg: register map, field positions, reset values, timing counts and
 * carrier types of the slow and main oscillator control block.
 * Assumes a single 10 MHz bus clock; oscillator levels arrive as pins.
 */
`default_nettype none
package osc_ctrl_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // clock and timing
    localparam int unsigned HCLK_PERIOD_NS = 100;
    localparam int unsigned XT_TICK_DIV    = 8;       // startup counter runs on slow clock / 8
    localparam int unsigned MEAS_FALLS     = 16;      // slow falling edges per measurement
    localparam logic [2:0]  DIV8_LAST      = 3'h7;
    localparam logic [4:0]  MEAS_LAST      = 5'h10;

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] SLOW_CFG_OFS    = 8'h00;
    localparam logic [7:0] MAIN_CTRL_OFS   = 8'h04;
    localparam logic [7:0] FREQ_RES_OFS    = 8'h08;
    localparam logic [7:0] STATUS_OFS      = 8'h0c;
    localparam logic [7:0] IRQ_EN_OFS      = 8'h10;
    localparam logic [7:0] IRQ_DIS_OFS     = 8'h14;
    localparam logic [7:0] IRQ_MASK_OFS    = 8'h18;

    // slow_clock_config fields
    localparam int SLOW_RC_EN_BIT  = 0;
    localparam int SLOW_XT_EN_BIT  = 1;
    localparam int SLOW_BYP_BIT    = 2;
    localparam int SLOW_SEL_BIT    = 3;
    localparam logic [3:0] SLOW_CFG_RESET = 4'h1;

    // main_osc_control fields
    localparam int MAIN_RC_EN_BIT  = 0;
    localparam int MAIN_XT_EN_BIT  = 1;
    localparam int MAIN_BYP_BIT    = 2;
    localparam int MAIN_CNT_LSB    = 8;
    localparam int MAIN_CNT_W      = 8;
    localparam int MAIN_SEL_BIT    = 24;

    // main_freq_result fields
    localparam int FREQ_CNT_W      = 16;
    localparam int FREQ_RDY_BIT    = 16;

    // power_status / irq bit positions
    localparam int ST_XT_BIT       = 0;
    localparam int ST_SLOW_SW_BIT  = 7;
    localparam int ST_MAIN_SW_BIT  = 16;
    localparam int ST_RC_BIT       = 17;
    localparam logic [31:0] IRQ_BITS = 32'h0003_0001;

    ////////////////////////////////////////////////////////////////////////////
    // carriers
    typedef struct packed {
        logic slow_rc;        // slow rc oscillator output
        logic slow_xtal;      // slow crystal oscillator output
        logic slow_pin;       // slow_crystal_in_pin, bypass clock
        logic main_rc;        // main rc oscillator output
        logic main_xtal;      // main crystal oscillator output
        logic main_pin;       // main_crystal_in_pin, bypass clock
    } osc_pins_t;

    typedef struct packed {
        logic slow_rc_on;
        logic slow_xtal_on;
        logic main_rc_on;
        logic main_xtal_on;
    } osc_en_t;

    typedef enum logic [1:0] {
        ON_A  = 2'b00,
        OFF_A = 2'b01,
        OFF_B = 2'b10,
        ON_B  = 2'b11
    } mux_state_t;
endpackage
`default_nettype wire

// ### logic/glitch_free_mux.sv
/*
 * glitch_free_mux: switches between two sampled clock levels without a runt pulse.
 * Assumes both sources are already synchronised to clk.
 */
`timescale 1ns/1ps
`default_nettype none
module glitch_free_mux (
    input  wire logic                    clk,
    input  wire logic                    rst_n,
    input  wire logic                    src_a,
    input  wire logic                    src_b,
    input  wire logic                    sel,
    output logic                         clk_out,
    output logic                         on_b
);
    import osc_ctrl_pkg::*;

    mux_state_t state_ff;
    mux_state_t nxt_state;
    logic       out_ff;
    logic       nxt_out;

    ////////////////////////////////////////////////////////////////////////////
    // drop the old source while low, take the new one while low
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ON_A:  if (sel && !src_a) nxt_state = OFF_A;
            OFF_A: begin
                if (sel && !src_b) nxt_state = ON_B;
                else if (!sel && !src_a) nxt_state = ON_A;
            end
            ON_B:  if (!sel && !src_b) nxt_state = OFF_B;
            OFF_B: begin
                if (!sel && !src_a) nxt_state = ON_A;
                else if (sel && !src_b) nxt_state = ON_B;
            end
        endcase
        nxt_out = (nxt_state == ON_A) ? src_a : (nxt_state == ON_B) ? src_b : 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ON_A;
            out_ff   <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            out_ff   <= nxt_out;
        end
    end

    assign clk_out = out_ff;
    // off states report the side not selected by sel, so a pending switch never reads as finished
    assign on_b    = (state_ff == ON_B) || ((state_ff == OFF_A || state_ff == OFF_B) && !sel);

    // a rising output is always a rising level of the source in use
    no_glitch_a: assert property (@(posedge clk) disable iff (!rst_n) // [RULE7]
        $rose(out_ff) |-> ((state_ff == ON_A) && $past(src_a)) || ((state_ff == ON_B) && $past(src_b)))
        else $error("mux output rose without its source");
endmodule
`default_nettype wire

// ### logic/osc_ctrl.sv
/*
 * osc_ctrl: slow and main oscillator selection, crystal startup counter,
 * status and interrupt, main clock frequency meter, AHB-Lite register slave.
 * Assumes oscillator outputs arrive as asynchronous pins and run slower than hclk/2.
 */
// Local design decision: register access over AHB-Lite.
// Functional notes
// [RULE1] config bit 0 enables slow rc
// [RULE2] config bit 1 enables slow crystal
// [RULE3] config bit 2 bypasses crystal with pin
// [RULE4] config bit 3 selects slow source
// [RULE5] slow config resets to one
// [RULE6] status shows slow switch completed
// [RULE7] crystal select starts it, switch glitch-free
// [RULE8] software sets bypass before select
// [RULE9] software waits five slow cycles before disable
// [RULE10] main rc enable, on after reset
// [RULE11] rc disable clears rc stable
// [RULE12] rc stable interrupts when enabled
// [RULE13] crystal off after reset, disable clears stable
// [RULE14] startup count on slow/8, then stable
// [RULE15] main select glitch-free, status and interrupt
// [RULE16] main bypass takes pin clock
// [RULE17] main control reset values rc on
// [RULE18] software ensures pin clock before bypass
// [RULE19] measurement starts on stable or reselection
// [RULE20] count main clocks for sixteen slow falls
// [RULE21] software order for rc to crystal
// [RULE22] result holds, ready clears at start
// [RULE23] slow switch status follows mux
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic                    hready,
    input  wire logic [31:0]             hwdata,
    output logic [31:0]                  hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire osc_ctrl_pkg::osc_pins_t pins,
    output osc_ctrl_pkg::osc_en_t        osc_en,
    output logic                         slow_clk,
    output logic                         primary_clk,
    output logic                         irq
);
    import osc_ctrl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // pin synchronisers
    osc_pins_t pin_meta_ff;
    osc_pins_t pin_sync_ff;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_ff <= '0;
            pin_sync_ff <= '0;
        end else begin
            pin_meta_ff <= pins;
            pin_sync_ff <= pin_meta_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // state
    logic [3:0]            slow_cfg_ff, nxt_slow_cfg;
    logic                  rc_en_ff, nxt_rc_en;
    logic                  xt_en_ff, nxt_xt_en;
    logic                  byp_ff, nxt_byp;
    logic                  sel_ff, nxt_sel;
    logic [MAIN_CNT_W-1:0] st_cnt_ff, nxt_st_cnt;      // written startup count
    logic [MAIN_CNT_W-1:0] xt_cnt_ff, nxt_xt_cnt;
    logic                  xt_run_ff, nxt_xt_run;
    logic                  xt_ok_ff, nxt_xt_ok;
    logic                  rc_ok_ff, nxt_rc_ok;
    logic [31:0]           mask_ff, nxt_mask;
    logic [2:0]            div_ff, nxt_div;
    logic [FREQ_CNT_W-1:0] fcnt_ff, nxt_fcnt;
    logic [4:0]            falls_ff, nxt_falls;
    logic                  meas_ff, nxt_meas;
    logic                  frdy_ff, nxt_frdy;
    logic                  stab_prev_ff, nxt_stab_prev;
    logic                  slow_prev_ff, nxt_slow_prev;
    logic                  main_prev_ff, nxt_main_prev;
    logic                  wr_pend_ff, nxt_wr_pend;
    logic [7:0]            wr_addr_ff, nxt_wr_addr;
    logic [31:0]           rdata_ff, nxt_rdata;

    logic slow_on_b;
    logic main_on_b;
    logic slow_rc_src;
    logic slow_xt_src;
    logic main_rc_src;
    logic main_xt_src;
    logic [31:0] status;
    logic [31:0] main_ctrl_word;

    ////////////////////////////////////////////////////////////////////////////
    // oscillator sources and enables
    assign slow_rc_src = pin_sync_ff.slow_rc & slow_cfg_ff[SLOW_RC_EN_BIT];              // [RULE1]
    assign slow_xt_src = slow_cfg_ff[SLOW_BYP_BIT] ? pin_sync_ff.slow_pin                // [RULE3]
                                                    : (pin_sync_ff.slow_xtal & osc_en.slow_xtal_on);
    assign main_rc_src = pin_sync_ff.main_rc & rc_en_ff;                                 // [RULE10]
    assign main_xt_src = byp_ff ? pin_sync_ff.main_pin : (pin_sync_ff.main_xtal & xt_en_ff); // [RULE16]

    // selecting the slow crystal powers it even if its enable is clear, unless bypassed; the main crystal needs its enable
    assign osc_en.slow_rc_on   = slow_cfg_ff[SLOW_RC_EN_BIT];                            // [RULE1]
    assign osc_en.slow_xtal_on = !slow_cfg_ff[SLOW_BYP_BIT]
                                 && (slow_cfg_ff[SLOW_XT_EN_BIT] || slow_cfg_ff[SLOW_SEL_BIT]); // [RULE2] [RULE7]
    assign osc_en.main_rc_on   = rc_en_ff;
    assign osc_en.main_xtal_on = xt_en_ff && !byp_ff;

    glitch_free_mux u_slow_mux (
        .clk     (hclk),
        .rst_n   (hresetn),
        .src_a   (slow_rc_src),
        .src_b   (slow_xt_src),
        .sel     (slow_cfg_ff[SLOW_SEL_BIT]),                                            // [RULE4]
        .clk_out (slow_clk),
        .on_b    (slow_on_b)
    );

    glitch_free_mux u_main_mux (
        .clk     (hclk),
        .rst_n   (hresetn),
        .src_a   (main_rc_src),
        .src_b   (main_xt_src),
        .sel     (sel_ff),                                                               // [RULE15]
        .clk_out (primary_clk),
        .on_b    (main_on_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // status words
    always_comb begin
        status                 = '0;
        status[ST_XT_BIT]      = xt_ok_ff;
        status[ST_SLOW_SW_BIT] = (slow_on_b == slow_cfg_ff[SLOW_SEL_BIT]);               // [RULE6] [RULE23]
        status[ST_MAIN_SW_BIT] = (main_on_b == sel_ff);                                  // [RULE15]
        status[ST_RC_BIT]      = rc_ok_ff;
        main_ctrl_word         = '0;
        main_ctrl_word[MAIN_RC_EN_BIT] = rc_en_ff;
        main_ctrl_word[MAIN_XT_EN_BIT] = xt_en_ff;
        main_ctrl_word[MAIN_BYP_BIT]   = byp_ff;
        main_ctrl_word[MAIN_CNT_LSB +: MAIN_CNT_W] = st_cnt_ff;
        main_ctrl_word[MAIN_SEL_BIT]   = sel_ff;
    end

    assign irq       = |(status & mask_ff);                                              // [RULE12]
    assign hrdata    = rdata_ff;
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // next state: bus, startup counter, frequency meter
    always_comb begin
        logic slow_fall;
        logic slow_rise;
        logic main_rise;
        logic tick8;
        logic stab_now;
        logic start;
        logic wr;
        slow_fall = slow_prev_ff && !slow_clk;
        slow_rise = !slow_prev_ff && slow_clk;
        main_rise = !main_prev_ff && primary_clk;
        tick8     = slow_rise && (div_ff == DIV8_LAST);
        stab_now  = main_on_b ? xt_ok_ff : rc_ok_ff;
        start     = stab_now && !stab_prev_ff;
        wr        = wr_pend_ff;

        nxt_slow_cfg  = slow_cfg_ff;
        nxt_rc_en     = rc_en_ff;
        nxt_xt_en     = xt_en_ff;
        nxt_byp       = byp_ff;
        nxt_sel       = sel_ff;
        nxt_st_cnt    = st_cnt_ff;
        nxt_xt_cnt    = xt_cnt_ff;
        nxt_xt_run    = xt_run_ff;
        nxt_xt_ok     = xt_ok_ff;
        nxt_rc_ok     = rc_ok_ff;
        nxt_mask      = mask_ff;
        nxt_div       = slow_rise ? div_ff + 3'h1 : div_ff;
        nxt_fcnt      = fcnt_ff;
        nxt_falls     = falls_ff;
        nxt_meas      = meas_ff;
        nxt_frdy      = frdy_ff;
        nxt_stab_prev = stab_now;
        nxt_slow_prev = slow_clk;
        nxt_main_prev = primary_clk;

        // address phase: capture write target, register read data
        nxt_wr_pend = hsel && hready && htrans[1] && hwrite;
        nxt_wr_addr = haddr[7:0];
        nxt_rdata   = rdata_ff;
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                SLOW_CFG_OFS:  nxt_rdata = {28'h0, slow_cfg_ff};
                MAIN_CTRL_OFS: nxt_rdata = main_ctrl_word;
                FREQ_RES_OFS:  nxt_rdata = {15'h0, frdy_ff, fcnt_ff};
                STATUS_OFS:    nxt_rdata = status;
                IRQ_MASK_OFS:  nxt_rdata = mask_ff;
                default:       nxt_rdata = 32'h0;
            endcase
        end

        // rc stable comes after a slow/8 tick, drops at once on disable
        if (tick8 && rc_en_ff) nxt_rc_ok = 1'b1;
        // crystal startup countdown on slow clock / 8
        if (tick8 && xt_run_ff) begin                                                   // [RULE14]
            if (xt_cnt_ff == '0) begin
                nxt_xt_ok  = 1'b1;
                nxt_xt_run = 1'b0;
            end else begin
                nxt_xt_cnt = xt_cnt_ff - 8'h01;
            end
        end

        // frequency meter
        if (meas_ff) begin
            if (main_rise) nxt_fcnt = fcnt_ff + 16'h0001;                               // [RULE20]
            if (slow_fall) begin
                nxt_falls = falls_ff + 5'h01;
                if (falls_ff + 5'h01 == MEAS_LAST) begin
                    nxt_meas = 1'b0;                                                    // [RULE20]
                    nxt_frdy = 1'b1;
                end
            end
        end

        // data phase writes
        if (wr) begin
            unique case (wr_addr_ff)
                SLOW_CFG_OFS: nxt_slow_cfg = hwdata[3:0];                               // [RULE1] [RULE2] [RULE3] [RULE4]
                MAIN_CTRL_OFS: begin
                    nxt_rc_en  = hwdata[MAIN_RC_EN_BIT];
                    nxt_xt_en  = hwdata[MAIN_XT_EN_BIT];
                    nxt_byp    = hwdata[MAIN_BYP_BIT];
                    nxt_sel    = hwdata[MAIN_SEL_BIT];
                    nxt_st_cnt = hwdata[MAIN_CNT_LSB +: MAIN_CNT_W];
                    if (!hwdata[MAIN_RC_EN_BIT]) nxt_rc_ok = 1'b0;                       // [RULE11]
                    if (!hwdata[MAIN_XT_EN_BIT]) begin
                        nxt_xt_ok  = 1'b0;                                               // [RULE13]
                        nxt_xt_run = 1'b0;
                    end else if (!xt_en_ff || hwdata[MAIN_CNT_LSB +: MAIN_CNT_W] != st_cnt_ff) begin
                        nxt_xt_ok  = 1'b0;                                               // [RULE14]
                        nxt_xt_run = 1'b1;
                        nxt_xt_cnt = hwdata[MAIN_CNT_LSB +: MAIN_CNT_W];
                    end
                    if (hwdata[MAIN_SEL_BIT] != sel_ff) start = 1'b1;                     // [RULE19]
                end
                IRQ_EN_OFS:  nxt_mask = mask_ff | (hwdata & IRQ_BITS);
                IRQ_DIS_OFS: nxt_mask = mask_ff & ~hwdata;
                default: ;
            endcase
        end

        // a start clears ready and restarts the count from zero
        if (start) begin                                                                 // [RULE19] [RULE22]
            nxt_meas  = 1'b1;
            nxt_frdy  = 1'b0;
            nxt_fcnt  = '0;
            nxt_falls = '0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            slow_cfg_ff  <= SLOW_CFG_RESET;                                              // [RULE5]
            rc_en_ff     <= 1'b1;                                                        // [RULE17]
            xt_en_ff     <= 1'b0;                                                        // [RULE13]
            byp_ff       <= 1'b0;
            sel_ff       <= 1'b0;
            st_cnt_ff    <= '0;
            xt_cnt_ff    <= '0;
            xt_run_ff    <= 1'b0;
            xt_ok_ff     <= 1'b0;
            rc_ok_ff     <= 1'b0;
            mask_ff      <= '0;
            div_ff       <= '0;
            fcnt_ff      <= '0;
            falls_ff     <= '0;
            meas_ff      <= 1'b0;
            frdy_ff      <= 1'b0;
            stab_prev_ff <= 1'b0;
            slow_prev_ff <= 1'b0;
            main_prev_ff <= 1'b0;
            wr_pend_ff   <= 1'b0;
            wr_addr_ff   <= '0;
            rdata_ff     <= '0;
        end else begin
            slow_cfg_ff  <= nxt_slow_cfg;
            rc_en_ff     <= nxt_rc_en;
            xt_en_ff     <= nxt_xt_en;
            byp_ff       <= nxt_byp;
            sel_ff       <= nxt_sel;
            st_cnt_ff    <= nxt_st_cnt;
            xt_cnt_ff    <= nxt_xt_cnt;
            xt_run_ff    <= nxt_xt_run;
            xt_ok_ff     <= nxt_xt_ok;
            rc_ok_ff     <= nxt_rc_ok;
            mask_ff      <= nxt_mask;
            div_ff       <= nxt_div;
            fcnt_ff      <= nxt_fcnt;
            falls_ff     <= nxt_falls;
            meas_ff      <= nxt_meas;
            frdy_ff      <= nxt_frdy;
            stab_prev_ff <= nxt_stab_prev;
            slow_prev_ff <= nxt_slow_prev;
            main_prev_ff <= nxt_main_prev;
            wr_pend_ff   <= nxt_wr_pend;
            wr_addr_ff   <= nxt_wr_addr;
            rdata_ff     <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // helper terms for the checks below
    logic tick_seen;
    logic wr_addr_ok;
    logic meas_live;
    assign tick_seen     = (div_ff == DIV8_LAST) && !slow_prev_ff && slow_clk;
    assign wr_addr_ok    = !(wr_pend_ff && wr_addr_ff == MAIN_CTRL_OFS);
    assign meas_live     = meas_ff;

    rc_off_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE11]
        $fell(rc_en_ff) |-> !rc_ok_ff)
        else $error("rc stable survived rc disable");
    xt_off_clear_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE13]
        !xt_en_ff |-> !xt_ok_ff)
        else $error("crystal stable while crystal disabled");
    xt_done_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE14]
        (xt_run_ff && xt_cnt_ff == '0 && tick_seen && wr_addr_ok) |=> xt_ok_ff)
        else $error("startup count reached zero without stable");
    irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE12]
        (rc_ok_ff && mask_ff[ST_RC_BIT]) |-> irq)
        else $error("unmasked rc stable without interrupt");
    meas_end_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE20]
        $rose(frdy_ff) |-> $past(meas_ff) && (falls_ff == MEAS_LAST) && !meas_ff)
        else $error("measurement ended at wrong slow edge");
    meas_hold_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE22]
        (frdy_ff && !meas_ff) ##1 !meas_live |-> $stable(fcnt_ff))
        else $error("frequency result changed while held");
    slow_sw_a: assert property (@(posedge hclk) disable iff (!hresetn) // [RULE23]
        ($changed(slow_cfg_ff[SLOW_SEL_BIT]) && $past(status[ST_SLOW_SW_BIT])) |-> !status[ST_SLOW_SW_BIT])
        else $error("slow switch status ahead of mux");
    bus_okay_a: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave answered other than okay");
endmodule
`default_nettype wire

// ### tb/osc_ctrl_tb.sv
/*
 * osc_ctrl_tb: self-checking bench for the slow and main oscillator control block.
 * Assumes the block is the only AHB-Lite slave and that oscillator pins toggle well below hclk/2.
 */
`timescale 1ns/1ps
`default_nettype none
module osc_ctrl_tb;
    import osc_ctrl_pkg::*;
    logic             hclk;
    logic             hresetn;
    logic             hsel;
    logic             hwrite;
    logic [31:0]      haddr;
    logic [31:0]      hwdata;
    logic [31:0]      q;
    logic [1:0]       htrans;
    logic [2:0]       hsize;
    logic [7:0]       cyc;
    osc_pins_t        pins;
    wire logic [31:0] hrdata;
    wire logic        hreadyout;
    wire logic        hresp;
    wire logic        slow_clk;
    wire logic        primary_clk;
    wire logic        irq;
    osc_en_t          osc_en;
    int               bad_count;
    int               comparisons;

    osc_ctrl dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .pins(pins), .osc_en(osc_en), .slow_clk(slow_clk), .primary_clk(primary_clk), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    // 100 ns bus clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    // oscillator levels: main rc 4 hclk, main crystal 8, slow rc 16, slow crystal 32, slow pin 8
    always @(posedge hclk) begin
        cyc <= cyc + 8'h01;
        pins <= '{slow_rc: cyc[3], slow_xtal: cyc[4], slow_pin: cyc[2], main_rc: cyc[1], main_xtal: cyc[2],
                  main_pin: cyc[2]};
    end

    ////////////////////////////////////////////////////////////////////////////
    // verdict, comparison and bus helpers
    task automatic complete_run;
        if (bad_count == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g, input int tol);
        comparisons++;
        if ((^g) === 1'bx || g > e + tol || g + tol < e) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    // one single transfer; waits for hready in each phase, read data lands in q
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        q = hrdata;
        if (hresp !== 1'b0) begin
            bad_count++;
            $display("[FAIL] hresp expected 0 seen %b", hresp);
        end
        if (n >= 100) begin
            bad_count++;
            complete_run;
        end
    endtask

    // polls a register bit until it reaches v, bounded
    task automatic wait_bit(input logic [7:0] a, input int b, input logic v);
        int i;
        for (i = 0; i < 600; i++) begin
            bus(1'b0, a, 32'h0);
            if (q[b] === v) break;
        end
        if (i >= 600) begin
            bad_count++;
            complete_run;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        bus(1'b0, SLOW_CFG_OFS, 32'h0);
        chk("slow_cfg", 32'h1, q, 0);
        bus(1'b0, MAIN_CTRL_OFS, 32'h0);
        chk("main_ctrl", 32'h1, q & 32'h0100_0007, 0);
        chk("osc_en", 32'ha, 32'(osc_en), 0);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q, 0);
    endtask

    task automatic t_rc;
        wait_bit(STATUS_OFS, ST_RC_BIT, 1'b1);
        wait_bit(FREQ_RES_OFS, FREQ_RDY_BIT, 1'b1);
        chk("rc_freq", 32'd64, {16'h0, q[15:0]}, 3);
        bus(1'b1, IRQ_EN_OFS, 32'h0002_0000);
        bus(1'b0, IRQ_MASK_OFS, 32'h0);
        chk("irq_mask", 32'h0002_0000, q, 0);
        chk("irq_rc", 32'h1, {31'h0, irq}, 0);
        bus(1'b1, IRQ_DIS_OFS, 32'h0002_0000);
        @(posedge hclk);
        chk("irq_off", 32'h0, {31'h0, irq}, 0);
    endtask

    // rc to crystal in the software order, then rc off and the crystal bypassed by its pin
    task automatic t_xtal;
        bus(1'b1, MAIN_CTRL_OFS, 32'h0000_0203);
        bus(1'b0, STATUS_OFS, 32'h0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("xt_clr", 32'h0, {31'h0, q[ST_XT_BIT]}, 0);
        wait_bit(STATUS_OFS, ST_XT_BIT, 1'b1);
        bus(1'b1, IRQ_EN_OFS, 32'h0000_0001);
        @(posedge hclk);
        chk("irq_xt", 32'h1, {31'h0, irq}, 0);
        bus(1'b1, MAIN_CTRL_OFS, 32'h0100_0203);
        wait_bit(STATUS_OFS, ST_MAIN_SW_BIT, 1'b1);
        bus(1'b0, FREQ_RES_OFS, 32'h0);
        chk("rdy_clr", 32'h0, {31'h0, q[FREQ_RDY_BIT]}, 0);
        wait_bit(FREQ_RES_OFS, FREQ_RDY_BIT, 1'b1);
        chk("xt_freq", 32'd32, {16'h0, q[15:0]}, 3);
        bus(1'b1, MAIN_CTRL_OFS, 32'h0100_0202);
        bus(1'b0, STATUS_OFS, 32'h0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("rc_clr", 32'h0, {31'h0, q[ST_RC_BIT]}, 0);
        chk("rc_off", 32'h0, {31'h0, osc_en.main_rc_on}, 0);
        bus(1'b1, MAIN_CTRL_OFS, 32'h0100_0206);
        bus(1'b1, MAIN_CTRL_OFS, 32'h0100_0204);
        bus(1'b0, STATUS_OFS, 32'h0);
        bus(1'b0, STATUS_OFS, 32'h0);
        chk("xt_off", 32'h0, {31'h0, q[ST_XT_BIT]}, 0);
        chk("irq_xt_off", 32'h0, {31'h0, irq}, 0);
        q = 32'h0;
        repeat (16) begin
            @(posedge hclk);
            q[0] = q[0] | primary_clk;
        end
        chk("byp_clk", 32'h1, q, 0);
    endtask

    // slow source table; bypass is set before select and the old source stays on until switched
    task automatic t_slow;
        logic [3:0] seq [4];
        seq = '{4'h3, 4'hb, 4'h5, 4'hd};
        foreach (seq[k]) begin
            bus(1'b1, SLOW_CFG_OFS, {28'h0, seq[k]});
            bus(1'b0, STATUS_OFS, 32'h0);
            wait_bit(STATUS_OFS, ST_SLOW_SW_BIT, 1'b1);
            bus(1'b0, SLOW_CFG_OFS, 32'h0);
            chk("slow_cfg", {28'h0, seq[k]}, q, 0);
            chk("slow_en", {30'h0, seq[k][0], (seq[k][1] | seq[k][3]) & ~seq[k][2]},
                {30'h0, osc_en.slow_rc_on, osc_en.slow_xtal_on}, 0);
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        pins = '0;
        cyc = 8'h00;
        bad_count = 0;
        comparisons = 0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset;
        t_rc;
        t_xtal;
        t_slow;
        complete_run;
    end
endmodule
`default_nettype wire
